// file: core/nvw_ctrl.sv
/*
 Data EEPROM write controller with APB register access, unlock sequence,
 power-up write lockout and write-complete interrupt.
 Assumes pclk at 20 MHz and presetn as the power-on reset.
*/
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "nvw_regs.svh"
`default_nettype none
module nvw_ctrl
    import nvw_pkg::*;
#(
    parameter int unsigned PWRT_CYCLES = `NVW_PWRT_CYCLES,
    parameter int unsigned WRITE_CYCLES = `NVW_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration fuse and external access path
    input wire logic data_code_protect,
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [7:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    output logic ext_grant,
    output logic [7:0] ext_rdata,
    // Interrupt and status
    output logic irq,
    output logic write_busy
);
    typedef struct packed {
        logic [7:0] nv_address_low;
        logic [7:0] nv_data_low;
        logic write_enable;
        logic write_bit;
        logic config_space_select;
        logic pgsel;
        logic rd_pend;
        nvw_key_e key;
        logic [7:0] peripheral_interrupt_flag_two;
        logic [7:0] peripheral_interrupt_enable_two;
        logic [31:0] pwrt_cnt;
        logic pwrt_done;
        logic [31:0] wr_cnt;
        logic [31:0] prdata;
        logic [7:0] ext_rdata;
        logic ext_grant;
        logic cp_s1;
        logic cp_s2;
        logic xr_s1;
        logic xr_s2;
    } nvw_state_s;

    nvw_state_s st;
    nvw_state_s next_st;
    nvw_mem_req_s mem_req;
    logic [7:0] mem_rdata;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic key_wr;
    logic ctrl_wr;
    logic wr_launch;
    logic wr_done;
    logic ext_ok;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    function automatic logic [31:0] rd_mux(input logic [11:0] a,
                                           input nvw_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (hit(a, `NVW_OFF_ADDR)) begin
            v[7:0] = s.nv_address_low;
        end else if (hit(a, `NVW_OFF_DATA)) begin
            v[7:0] = s.nv_data_low;
        end else if (hit(a, `NVW_OFF_CTRL)) begin
            v[`NVW_CTRL_WR] = s.write_bit;
            v[`NVW_CTRL_WEN] = s.write_enable;
            v[`NVW_CTRL_CSEL] = s.config_space_select;
            v[`NVW_CTRL_PGSEL] = s.pgsel;
        end else if (hit(a, `NVW_OFF_IRQ_FLAG)) begin
            v[7:0] = s.peripheral_interrupt_flag_two;
        end else if (hit(a, `NVW_OFF_IRQ_EN)) begin
            v[7:0] = s.peripheral_interrupt_enable_two;
        end
        return v;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return hit(a, `NVW_OFF_ADDR) || hit(a, `NVW_OFF_DATA) ||
               hit(a, `NVW_OFF_CTRL) || hit(a, `NVW_OFF_KEY) ||
               hit(a, `NVW_OFF_IRQ_FLAG) || hit(a, `NVW_OFF_IRQ_EN);
    endfunction

    nvw_array u_array (
        .pclk(pclk),
        .req(mem_req),
        .rdata(mem_rdata)
    );

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign acc = psel && penable && mapped(paddr);
    assign wr_acc = acc && pwrite;
    // Read word captured at the setup edge so it stands at the access edge
    assign rd_acc = psel && !penable && !pwrite && mapped(paddr);
    assign key_wr = wr_acc && hit(paddr, `NVW_OFF_KEY);
    assign ctrl_wr = wr_acc && hit(paddr, `NVW_OFF_CTRL);
    assign wr_done = st.write_bit && st.wr_cnt == 32'd1;

    // Write launches only when armed, enabled, timer over and idle
    assign wr_launch = ctrl_wr && pwdata[`NVW_CTRL_WR] &&
                       st.key == NVW_KEY_ARMED &&
                       st.write_enable &&
                       st.pwrt_done &&
                       !st.write_bit;

    // A completing write always has the array; outside path only when unprotected
    assign ext_ok = st.cp_s2 && st.xr_s2 && !st.write_bit &&
                    !st.rd_pend;

    always_comb begin
        mem_req.we = 1'b0;
        mem_req.addr = st.nv_address_low;
        mem_req.wdata = st.nv_data_low;
        if (wr_done) begin
            mem_req.we = 1'b1;
        end else if (!st.rd_pend && ext_ok) begin
            mem_req.we = ext_we;
            mem_req.addr = ext_addr;
            mem_req.wdata = ext_wdata;
        end
    end

    assign prdata = st.prdata;
    assign ext_rdata = st.ext_rdata;
    assign ext_grant = st.ext_grant;
    assign irq = |(st.peripheral_interrupt_flag_two &
                   st.peripheral_interrupt_enable_two);
    assign write_busy = st.write_bit;

    always_comb begin
        next_st = st;
        next_st.cp_s1 = data_code_protect;
        next_st.cp_s2 = st.cp_s1;
        next_st.xr_s1 = ext_req;
        next_st.xr_s2 = st.xr_s1;
        next_st.rd_pend = 1'b0;
        next_st.ext_grant = ext_ok;
        if (ext_ok && !ext_we) begin
            next_st.ext_rdata = mem_rdata;
        end
        if (rd_acc) begin
            next_st.prdata = rd_mux(paddr, st);
        end

        if (st.pwrt_cnt < PWRT_CYCLES) begin
            next_st.pwrt_cnt = st.pwrt_cnt + 32'd1;
        end else begin
            next_st.pwrt_done = 1'b1;
        end

        if (st.rd_pend) begin
            next_st.nv_data_low = mem_rdata;
        end

        // Unlock sequencer: any other mapped access restarts from the first key
        if (acc) begin
            next_st.key = NVW_KEY_IDLE;
            if (key_wr && pwdata[7:0] == `NVW_KEY_FIRST) begin
                next_st.key = NVW_KEY_GOT55;
            end else if (key_wr && st.key == NVW_KEY_GOT55 &&
                         pwdata[7:0] == `NVW_KEY_SECOND) begin
                next_st.key = NVW_KEY_ARMED;
            end
        end

        if (wr_acc && hit(paddr, `NVW_OFF_ADDR)) begin
            next_st.nv_address_low = pwdata[7:0];
        end
        // Bus writes to the data register blocked while a write uses it
        if (wr_acc && hit(paddr, `NVW_OFF_DATA) && !st.write_bit) begin
            next_st.nv_data_low = pwdata[7:0];
        end
        if (ctrl_wr) begin
            next_st.write_enable = pwdata[`NVW_CTRL_WEN];
            next_st.config_space_select = pwdata[`NVW_CTRL_CSEL];
            next_st.pgsel = pwdata[`NVW_CTRL_PGSEL];
            // Read is allowed whatever code protect says
            if (pwdata[`NVW_CTRL_RD] && !pwdata[`NVW_CTRL_CSEL] &&
                !pwdata[`NVW_CTRL_PGSEL] && !st.write_bit) begin
                next_st.rd_pend = 1'b1;
            end
        end
        if (wr_launch) begin
            next_st.write_bit = 1'b1;
            next_st.wr_cnt = WRITE_CYCLES;
        end else if (st.write_bit) begin
            next_st.wr_cnt = st.wr_cnt - 32'd1;
        end
        if (wr_done) begin
            next_st.write_bit = 1'b0;
        end

        // Write one to clear; a same-cycle set wins
        if (wr_acc && hit(paddr, `NVW_OFF_IRQ_FLAG)) begin
            next_st.peripheral_interrupt_flag_two =
                st.peripheral_interrupt_flag_two & ~pwdata[7:0];
        end
        if (wr_done) begin
            next_st.peripheral_interrupt_flag_two[`NVW_IRQ_BIT] =
                1'b1;
        end
        if (wr_acc && hit(paddr, `NVW_OFF_IRQ_EN)) begin
            next_st.peripheral_interrupt_enable_two = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.key <= NVW_KEY_IDLE;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// file: core/nvw_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 data EEPROM write controller. Assumes a 32-bit APB slave at pclk 20 MHz.
*/
`ifndef NVW_REGS_SVH
`define NVW_REGS_SVH

`define NVW_OFF_ADDR 12'h000
`define NVW_OFF_DATA 12'h004
`define NVW_OFF_CTRL 12'h008
`define NVW_OFF_KEY 12'h00c
`define NVW_OFF_IRQ_FLAG 12'h010
`define NVW_OFF_IRQ_EN 12'h014

// Control register bits
`define NVW_CTRL_RD 0
`define NVW_CTRL_WR 1
`define NVW_CTRL_WEN 2
`define NVW_CTRL_WRERR 3
`define NVW_CTRL_CSEL 6
`define NVW_CTRL_PGSEL 7
// Flag and enable bit of the write-complete event
`define NVW_IRQ_BIT 4

`define NVW_KEY_FIRST 8'h55
`define NVW_KEY_SECOND 8'haa

`define NVW_RESET_BYTE 8'h00

`define NVW_PWRT_MS 64
`define NVW_CLK_HZ 20000000
`define NVW_PWRT_CYCLES ((`NVW_PWRT_MS * `NVW_CLK_HZ) / 1000)
`define NVW_WRITE_CYCLES 40000

`endif

// file: core/nvw_pkg.sv
/*
 Types shared by the data EEPROM write controller and its array.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package nvw_pkg;
    typedef enum logic [1:0] {
        NVW_KEY_IDLE,
        NVW_KEY_GOT55,
        NVW_KEY_ARMED
    } nvw_key_e;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvw_mem_req_s;
endpackage
`default_nettype wire

// file: core/nvw_array.sv
/*
 256 x 8 data EEPROM array. Assumes one write or read request per cycle;
 read data is registered and valid the cycle after the request.
*/
`default_nettype none
module nvw_array
    import nvw_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Request
    input wire nvw_mem_req_s req,
    // Read data
    output logic [7:0] rdata
);
    logic [7:0] mem [0:255];

    always_ff @(posedge pclk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
        rdata <= mem[req.addr];
    end
endmodule
`default_nettype wire

// file: bench/nvw_ctrl_checker.sv
/*
 Port assertions for the data EEPROM write controller.
 Assumes one clock pclk and bind to every nvw_ctrl instance.
*/
`default_nettype none
module nvw_ctrl_checker #(
    parameter int unsigned PWRT_CYCLES = 20,
    parameter int unsigned WRITE_CYCLES = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Fuse and outputs
    input wire logic data_code_protect,
    input wire logic ext_grant,
    input wire logic irq,
    input wire logic write_busy
);
    int unsigned up;
    int unsigned bcnt;
    logic acc;
    assign acc = psel && penable;
    // up saturates so long timer values cost no wide counter wrap; bcnt clears when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= '0;
            bcnt <= '0;
        end else begin
            up <= (up < PWRT_CYCLES) ? up + 1 : up;
            bcnt <= write_busy ? bcnt + 1 : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    write_start_a: assert property ($rose(write_busy) |-> $past(acc &&
        pwrite && paddr == 12'h008 && pwdata[1])) else $error("bad start");
    busy_length_a: assert property ($fell(write_busy) |->
        bcnt >= WRITE_CYCLES - 1 && bcnt <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    busy_bound_a: assert property (write_busy |->
        bcnt <= WRITE_CYCLES + 1) else $error("write never ends");
    power_lock_a: assert property (write_busy |->
        up >= PWRT_CYCLES - 1) else $error("write during power-up");
    flag_sticky_a: assert property ($fell(irq) |->
        $past(acc && pwrite)) else $error("irq fell without software");
    irq_cause_a: assert property ($rose(irq) |-> $fell(write_busy) ||
        $past(acc && pwrite && paddr == 12'h014)) else $error("stray irq");
    protect_a: assert property (!data_code_protect [*5] |->
        !ext_grant) else $error("outside access while protected");
    unmapped_a: assert property (acc |-> pslverr == (paddr > 12'h014))
        else $error("slave error wrong");
endmodule
bind nvw_ctrl nvw_ctrl_checker #(.PWRT_CYCLES(PWRT_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .irq(irq), .ext_grant(ext_grant),
    .data_code_protect(data_code_protect), .write_busy(write_busy));
`default_nettype wire

// file: bench/nvw_apb_master.sv
/*
 APB master standing in for the processor core.
 Assumes the bench watchdog ends a wait that never sees pready.
*/
`default_nettype none
module nvw_apb_master (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // Answer and read data are taken at the edge that sees pready high
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: bench/nvw_ctrl_tb.sv
/*
 Self-checking bench: unlock order, lockouts, flag, read, code protect.
 Assumes nvw_ctrl with short timer counts and its bound checker.
*/
`include "nvw_regs.svh"
`default_nettype none
module nvw_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, write_busy, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] ext_rdata;
    logic dcp = 1'b1;
    logic ext_req = 1'b0;
    logic ext_grant;
    int err_count = 0;
    int tests_run = 0;
    always #25 pclk = ~pclk;
    nvw_apb_master i_cpu (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    nvw_ctrl #(.PWRT_CYCLES(40), .WRITE_CYCLES(10)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_code_protect(dcp), .ext_req(ext_req),
        .ext_we(1'b0), .ext_addr(8'h12), .ext_wdata(8'h00),
        .ext_grant(ext_grant), .ext_rdata(ext_rdata), .irq(irq),
        .write_busy(write_busy));
    task automatic chk(input string n, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b1, a, {24'h0, d}, q, e);
        // Outputs launched at the access edge are settled by the falling edge
        @(negedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b0, a, 32'h0, q, e);
        chk("prdata", q, {24'h0, d});
    endtask
    // Three steps with nothing in between, as an interrupt-free core would
    task automatic arm();
        wr(`NVW_OFF_KEY, 8'h55);
        wr(`NVW_OFF_KEY, 8'haa);
        wr(`NVW_OFF_CTRL, 8'h06);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`NVW_OFF_CTRL, 8'h00);
        wr(`NVW_OFF_CTRL, 8'h04);
        arm();
        chk("busy", 32'(write_busy), 32'h0);
        repeat (40) @(posedge pclk);
        wr(`NVW_OFF_ADDR, 8'h12);
        wr(`NVW_OFF_DATA, 8'ha5);
        wr(`NVW_OFF_CTRL, 8'h00);
        arm();
        chk("busy", 32'(write_busy), 32'h0);
        wr(`NVW_OFF_CTRL, 8'h04);
        wr(`NVW_OFF_KEY, 8'haa);
        wr(`NVW_OFF_KEY, 8'h55);
        wr(`NVW_OFF_CTRL, 8'h06);
        chk("busy", 32'(write_busy), 32'h0);
        wr(`NVW_OFF_KEY, 8'h55);
        rd(`NVW_OFF_ADDR, 8'h12);
        wr(`NVW_OFF_KEY, 8'haa);
        wr(`NVW_OFF_CTRL, 8'h06);
        chk("busy", 32'(write_busy), 32'h0);
        rd(`NVW_OFF_CTRL, 8'h04);
        arm();
        chk("busy", 32'(write_busy), 32'h1);
        wr(`NVW_OFF_CTRL, 8'h00);
        chk("busy", 32'(write_busy), 32'h1);
        for (int i = 0; i < 20 && write_busy; i++) @(posedge pclk);
        chk("busy", 32'(write_busy), 32'h0);
        rd(`NVW_OFF_IRQ_FLAG, 8'h10);
        chk("irq", 32'(irq), 32'h0);
        wr(`NVW_OFF_IRQ_EN, 8'h10);
        chk("irq", 32'(irq), 32'h1);
        repeat (20) @(posedge pclk);
        rd(`NVW_OFF_IRQ_FLAG, 8'h10);
        wr(`NVW_OFF_IRQ_FLAG, 8'h10);
        chk("irq", 32'(irq), 32'h0);
        wr(`NVW_OFF_DATA, 8'h00);
        @(posedge pclk);
        dcp <= 1'b0;
        wr(`NVW_OFF_CTRL, 8'h01);
        rd(`NVW_OFF_DATA, 8'ha5);
        ext_req <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("grant", 32'(ext_grant), 32'h0);
        dcp <= 1'b1;
        for (int i = 0; i < 10 && !ext_grant; i++) @(posedge pclk);
        chk("grant", 32'(ext_grant), 32'h1);
        ext_req <= 1'b0;
        i_cpu.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("slverr", 32'(e), 32'h1);
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
